// ===== timer_event_pkg.sv
// constants and carrier types for the 8-bit timer/event counter
package timer_event_pkg;

   // ---------------------------------------------------------------
   // register addresses
   // ---------------------------------------------------------------
   localparam logic [15:0] PORT_TWO_DIRECTION_ADDR = 16'hFF22;
   localparam logic [15:0] TIMER_CONTROL_ADDR = 16'hFF53;
   localparam logic [15:0] COMPARE_VALUE_ADDR = 16'hFF52;
   localparam logic [15:0] COUNT_VALUE_ADDR = 16'hFF51;
   localparam logic [15:0] PORT_TWO_LATCH_ADDR = 16'hFF02;

   // ---------------------------------------------------------------
   // reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] PORT_TWO_DIRECTION_RESET = 8'hFF;
   localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] PORT_TWO_LATCH_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam int OUTPUT_PIN_BIT = 4;
   localparam int INPUT_PIN_BIT = 5;
   localparam int PORT_PINS = 6;

   // count clock selections
   localparam logic [1:0] SEL_SYS_CLK = 2'h0;
   localparam logic [1:0] SEL_SYS_DIV8 = 2'h1;
   localparam logic [1:0] SEL_EDGE_RISE = 2'h2;
   localparam logic [1:0] SEL_EDGE_FALL = 2'h3;

   // divide-by-2^3 prescaler terminal count
   localparam logic [2:0] PRESCALE_LAST = 3'h7;

   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic run_enable_bit;
      logic pwm_mode_bit;
      logic [2:0] zero_bits;
      logic clock_select_high;
      logic clock_select_low_edge;
      logic timer_output_enable_bit;
   } timer_ctrl_s;

endpackage

// ===== timer_event_counter.sv
// 8-bit timer/event counter with port 2 direction control
// Overview of operation
// - low six direction bits: 0 drives the pin, 1 releases it as input
// - reset loads the direction register with all ones
// - control: bit7 run, bit6 pwm, bits 2..1 clock select, bit0 output enable
// - clock select 00 system, 01 system/8, 10 rising input, 11 falling input
// - while run is 0 counting stops and the counter is held at zero
// - compare register takes any value 00 to FF, undefined after reset
// - interval mode: match clears counter, counting goes on, interrupt raised
// - event mode counts one per valid edge of the chosen polarity
// - square mode: match inverts output, clears counter, raises interrupt
// - square output forced low while run is 0
// - with output enabled the output starts low before any transition
// - pwm mode: match raises interrupt, counter not cleared, full 8-bit range
// - compare change during pwm may give one whole high cycle
`timescale 1ns/1ps
`default_nettype none

module timer_event_counter (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [15:0] mem_addr,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   input wire logic [5:0] port_pin_in,
   output logic [5:0] port_pin_out,
   output logic [5:0] port_pin_oe,
   output logic match_interrupt,
   output logic timer_output_pin
);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] port_two_direction;
   logic [7:0] port_two_latch;
   timer_event_pkg::timer_ctrl_s timer_control_reg;
   logic [7:0] compare_value_reg;
   logic [7:0] count_value;
   logic [2:0] prescale;
   logic [2:0] ev_sync;
   logic ev_level;
   logic count_tick;
   logic cmp_match;
   logic ev_rise;
   logic ev_fall;
   logic run;
   logic pwm;
   logic [1:0] clk_sel;

   // address decode helper used by the write paths; the read path decodes with a case
   function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
      hit = (a == target);
   endfunction

   assign run = timer_control_reg.run_enable_bit;
   assign pwm = timer_control_reg.pwm_mode_bit;
   assign clk_sel = {timer_control_reg.clock_select_high,
                     timer_control_reg.clock_select_low_edge};

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   // direction register, forced to all inputs at reset
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         port_two_direction <= timer_event_pkg::PORT_TWO_DIRECTION_RESET;
      end else if (mem_wr && hit(mem_addr, timer_event_pkg::PORT_TWO_DIRECTION_ADDR)) begin
         port_two_direction <= {2'h3, mem_wdata[5:0]}; // top bits always read one
      end
   end

   // port output latch
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         port_two_latch <= timer_event_pkg::PORT_TWO_LATCH_RESET;
      end else if (mem_wr && hit(mem_addr, timer_event_pkg::PORT_TWO_LATCH_ADDR)) begin
         port_two_latch <= {2'h0, mem_wdata[5:0]};
      end
   end

   // control register; bits 5..3 always zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         timer_control_reg <= timer_event_pkg::TIMER_CONTROL_RESET;
      end else if (mem_wr && hit(mem_addr, timer_event_pkg::TIMER_CONTROL_ADDR)) begin
         timer_control_reg <= {mem_wdata[7:6], 3'h0, mem_wdata[2:0]};
      end
   end

   // compare register has no reset: its content is undefined until written
   always_ff @(posedge sys_clk) begin
      if (mem_wr && hit(mem_addr, timer_event_pkg::COMPARE_VALUE_ADDR)) begin
         compare_value_reg <= mem_wdata;
      end
   end

   // read data, registered one cycle after the read strobe
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mem_rdata <= 8'h00;
      end else if (mem_rd) begin
         case (mem_addr)
            timer_event_pkg::PORT_TWO_DIRECTION_ADDR: mem_rdata <= port_two_direction;
            timer_event_pkg::PORT_TWO_LATCH_ADDR: mem_rdata <= port_two_latch;
            timer_event_pkg::TIMER_CONTROL_ADDR: mem_rdata <= timer_control_reg;
            timer_event_pkg::COMPARE_VALUE_ADDR: mem_rdata <= compare_value_reg;
            timer_event_pkg::COUNT_VALUE_ADDR: mem_rdata <= count_value;
            default: mem_rdata <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // event input synchroniser and edge detect
   // ---------------------------------------------------------------
   // three stages; a change is taken only when stages two and three agree
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ev_sync <= 3'h0;
      end else begin
         ev_sync <= {ev_sync[1:0], port_pin_in[timer_event_pkg::INPUT_PIN_BIT]};
      end
   end

   // settled level of the event pin, filters single-stage glitches
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ev_level <= 1'b0;
      end else if (ev_sync[1] == ev_sync[2]) begin
         ev_level <= ev_sync[2];
      end
   end

   assign ev_rise = ev_sync[1] && ev_sync[2] && !ev_level;
   assign ev_fall = !ev_sync[1] && !ev_sync[2] && ev_level;

   // ---------------------------------------------------------------
   // count clock selection
   // ---------------------------------------------------------------
   // prescaler restarts with run so the first divided tick is a full period
   always_ff @(posedge sys_clk) begin
      if (reset || !run) begin
         prescale <= 3'h0;
      end else begin
         prescale <= prescale + 3'h1;
      end
   end

   // one-cycle count enable from the selected source
   always_comb begin
      case (clk_sel)
         timer_event_pkg::SEL_SYS_CLK: count_tick = run;
         timer_event_pkg::SEL_SYS_DIV8:
            count_tick = run && (prescale == timer_event_pkg::PRESCALE_LAST);
         timer_event_pkg::SEL_EDGE_RISE: count_tick = run && ev_rise;
         timer_event_pkg::SEL_EDGE_FALL: count_tick = run && ev_fall;
         default: count_tick = 1'b0;
      endcase
   end

   assign cmp_match = (count_value == compare_value_reg);

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   // clearing modes give (compare + 1) ticks per period; pwm wraps at 256
   always_ff @(posedge sys_clk) begin
      if (reset || !run) begin
         count_value <= timer_event_pkg::COUNT_RESET;
      end else if (count_tick) begin
         if (cmp_match && !pwm) begin
            count_value <= timer_event_pkg::COUNT_RESET;
         end else begin
            count_value <= count_value + 8'h01;
         end
      end
   end

   // match pulse, one cycle, in the same cycle the counter clears
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         match_interrupt <= 1'b0;
      end else begin
         match_interrupt <= count_tick && cmp_match;
      end
   end

   // ---------------------------------------------------------------
   // timer output
   // ---------------------------------------------------------------
   // a late compare change in pwm can miss the wrap edge and stay high a cycle
   always_ff @(posedge sys_clk) begin
      if (reset || !run || !timer_control_reg.timer_output_enable_bit) begin
         timer_output_pin <= 1'b0;
      end else if (count_tick) begin
         if (pwm) begin
            if (cmp_match) begin
               timer_output_pin <= 1'b1;
            end else if (count_value == timer_event_pkg::COUNT_MAX) begin
               timer_output_pin <= 1'b0;
            end
         end else if (cmp_match) begin
            timer_output_pin <= !timer_output_pin;
         end
      end
   end

   // ---------------------------------------------------------------
   // port pins
   // ---------------------------------------------------------------
   // timer output is ored into the latch, which software keeps at zero
   always_comb begin
      port_pin_out = port_two_latch[5:0];
      port_pin_out[timer_event_pkg::OUTPUT_PIN_BIT] =
         port_two_latch[timer_event_pkg::OUTPUT_PIN_BIT] | timer_output_pin;
      port_pin_oe = ~port_two_direction[5:0];
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence s_match_tick;
      run && count_tick && cmp_match;
   endsequence

   // a count tick that reaches the output stage
   sequence s_out_tick;
      run && timer_control_reg.timer_output_enable_bit && count_tick;
   endsequence

   // reset value and register writes land where software expects them
   a_dir_reset: assert property (@(posedge sys_clk) disable iff (1'h0)
      reset |=> port_two_direction == timer_event_pkg::PORT_TWO_DIRECTION_RESET)
      else $error("direction register not all ones after reset");
   a_pin_oe_dir: assert property (
      mem_wr && mem_addr == timer_event_pkg::PORT_TWO_DIRECTION_ADDR
      |=> port_pin_oe == ~$past(mem_wdata[5:0]))
      else $error("pin enable does not follow direction bit");
   a_compare_write: assert property (
      mem_wr && mem_addr == timer_event_pkg::COMPARE_VALUE_ADDR
      |=> compare_value_reg == $past(mem_wdata))
      else $error("compare register did not take written value");
   a_ctrl_write: assert property (
      mem_wr && mem_addr == timer_event_pkg::TIMER_CONTROL_ADDR
      |=> run == $past(mem_wdata[7]) && pwm == $past(mem_wdata[6])
      && clk_sel == $past(mem_wdata[2:1]))
      else $error("control fields not at their bit positions");

   // counting and output behaviour
   a_stop_clears: assert property (
      !run |=> count_value == 8'h00)
      else $error("counter not zero while stopped");
   a_count_step: assert property (
      run && clk_sel == timer_event_pkg::SEL_SYS_CLK && !cmp_match
      |=> count_value == $past(count_value) + 8'h01)
      else $error("system clock tick not counted");
   a_interval_clear: assert property (
      (s_match_tick and !pwm) |=> (count_value == 8'h00) && match_interrupt)
      else $error("interval match did not clear and interrupt");
   a_square_toggle: assert property (
      (s_match_tick and !pwm && timer_control_reg.timer_output_enable_bit && run)
      ##1 run |-> timer_output_pin != $past(timer_output_pin))
      else $error("square output did not invert on match");
   a_stop_low: assert property (
      !run |=> !timer_output_pin)
      else $error("output not low while stopped");
   a_pwm_no_clear: assert property (
      (s_match_tick and pwm && count_value != 8'hFF)
      |=> count_value == $past(count_value) + 8'h01)
      else $error("pwm match cleared the counter");
   a_pwm_rise: assert property (
      (s_out_tick and pwm && cmp_match)
      |=> timer_output_pin)
      else $error("pwm output not high after match");
   a_pwm_wrap_low: assert property (
      run && pwm && timer_control_reg.timer_output_enable_bit && count_tick
      && count_value == 8'hFF && !cmp_match |=> !timer_output_pin)
      else $error("pwm output not low after wrap");
   a_div8_gap: assert property (
      run && clk_sel == 2'h1 && count_tick |=> (!count_tick)[*7])
      else $error("divided tick came early");
   a_edge_count: assert property (
      run && clk_sel == 2'h2 && ev_rise && !cmp_match
      |=> count_value == $past(count_value) + 8'h01)
      else $error("rising edge not counted");
   a_edge_fall: assert property (
      run && clk_sel == timer_event_pkg::SEL_EDGE_FALL && ev_fall && !cmp_match
      |=> count_value == $past(count_value) + 8'h01)
      else $error("falling edge not counted");

endmodule // timer_event_counter

`default_nettype wire

// ===== pin_partner.sv
// far-side model: port pin load with pull-ups and the external event source
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
   input wire logic [5:0] port_pin_out,
   input wire logic [5:0] port_pin_oe,
   input wire logic event_level,
   output logic [5:0] port_pin_in
);
   // ---------------------------------------------------------------
   // pin resolution
   // ---------------------------------------------------------------
   // a released pin floats to its pull-up, so an undriven pin never reads a stale level
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         port_pin_in[i] = port_pin_oe[i] ? port_pin_out[i] : 1'b1;
      end
      // event source drives only while the device has released the pin
      if (port_pin_oe[5] == 1'b0) begin
         port_pin_in[5] = event_level;
      end
   end
endmodule // pin_partner

`default_nettype wire

// ===== timer_event_counter_tb.sv
// self-checking testbench for the 8-bit timer/event counter
`timescale 1ns/1ps
`default_nettype none

module timer_event_counter_tb;
   logic sys_clk, reset, mem_wr, mem_rd, event_level, match_interrupt, timer_output_pin;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata;
   logic [5:0] port_pin_in, port_pin_out, port_pin_oe;
   int miscompares = 0;
   int n_checks = 0;
   int irq_cnt = 0;

   timer_event_counter u_dut (.sys_clk(sys_clk), .reset(reset), .mem_addr(mem_addr),
      .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
      .match_interrupt(match_interrupt), .timer_output_pin(timer_output_pin));
   pin_partner u_pins (.port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
      .event_level(event_level), .port_pin_in(port_pin_in));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // interrupt pulses tallied at the edge so readers at the falling edge see settled counts
   always @(posedge sys_clk) if (match_interrupt === 1'b1) irq_cnt <= irq_cnt + 1;

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one idle cycle after each strobe keeps back-to-back calls from double-driving it
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      mem_addr = a;
      mem_wdata = d;
      mem_wr = 1'b1;
      @(negedge sys_clk);
      mem_wr = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
      @(negedge sys_clk);
      mem_addr = a;
      mem_rd = 1'b1;
      @(negedge sys_clk);
      mem_rd = 1'b0;
      @(negedge sys_clk);
      chk({1'b0, mem_rdata}, {1'b0, exp}, what);
   endtask

   // returns cycles waited; a hang counts as a mismatch and ends the run
   task automatic wait_irq(output int n);
      n = 0;
      @(negedge sys_clk);
      while (match_interrupt !== 1'b1) begin
         n++;
         if (n > 2000) begin
            miscompares++;
            $display("mismatch at %0t: no interrupt", $time);
            stop_test();
         end
         @(negedge sys_clk);
      end
   endtask

   task automatic period(input logic [8:0] exp);
      int n;
      wait_irq(n);
      wait_irq(n);
      chk(9'(n + 1), exp, "interrupt period");
   endtask

   task automatic pulses(input int k);
      repeat (k) begin
         event_level = ~event_level;
         repeat (4) @(negedge sys_clk);
         event_level = ~event_level;
         repeat (4) @(negedge sys_clk);
      end
      repeat (4) @(negedge sys_clk);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd(timer_event_pkg::PORT_TWO_DIRECTION_ADDR, 8'hFF, "direction reset");
      chk({3'h0, port_pin_oe}, 9'h000, "enables after reset");
      rd(timer_event_pkg::TIMER_CONTROL_ADDR, 8'h00, "control reset");
      rd(timer_event_pkg::COUNT_VALUE_ADDR, 8'h00, "count reset");
      rd(16'hFF00, 8'h00, "unmapped read");
   endtask

   task automatic t_direction();
      wr(timer_event_pkg::PORT_TWO_DIRECTION_ADDR, 8'h00);
      chk({3'h0, port_pin_oe}, 9'h03F, "all outputs");
      rd(timer_event_pkg::PORT_TWO_DIRECTION_ADDR, 8'hC0, "direction top bits");
      wr(timer_event_pkg::PORT_TWO_DIRECTION_ADDR, 8'hEF);
      chk({3'h0, port_pin_oe}, 9'h010, "timer pin only");
   endtask

   task automatic t_interval(input logic [7:0] ctl, input logic [7:0] cmp, input logic [8:0] p);
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, ctl);
      wr(timer_event_pkg::COMPARE_VALUE_ADDR, cmp);
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, ctl | 8'h80);
      period(p);
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, ctl);
      rd(timer_event_pkg::COUNT_VALUE_ADDR, 8'h00, "count held when stopped");
   endtask

   task automatic t_square();
      int n;
      wr(timer_event_pkg::PORT_TWO_LATCH_ADDR, 8'h00);
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, 8'h01);
      wr(timer_event_pkg::COMPARE_VALUE_ADDR, 8'h04);
      chk({8'h00, timer_output_pin}, 9'h000, "output starts low");
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, 8'h81);
      wait_irq(n);
      chk({8'h00, port_pin_in[4]}, 9'h001, "pin high after match");
      chk({8'h00, timer_output_pin}, 9'h001, "output high after match");
      wait_irq(n);
      chk(9'(n + 1), 9'h005, "half period");
      chk({8'h00, timer_output_pin}, 9'h000, "second toggle");
      chk({8'h00, port_pin_in[4]}, 9'h000, "pin driven low by timer");
      wait_irq(n);
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, 8'h01);
      @(negedge sys_clk);
      chk({8'h00, timer_output_pin}, 9'h000, "forced low on stop");
   endtask

   task automatic t_event(input logic [7:0] sel, input logic start);
      int base;
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, 8'h00);
      event_level = start;
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, sel);
      wr(timer_event_pkg::COMPARE_VALUE_ADDR, 8'h02);
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, sel | 8'h80);
      base = irq_cnt;
      pulses(2);
      chk(9'(irq_cnt - base), 9'h000, "no match after two edges");
      pulses(1);
      chk(9'(irq_cnt - base), 9'h001, "match on third edge");
   endtask

   task automatic t_pwm();
      int n;
      int hi;
      hi = 0;
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, 8'h41);
      wr(timer_event_pkg::COMPARE_VALUE_ADDR, 8'h80);
      wr(timer_event_pkg::TIMER_CONTROL_ADDR, 8'hC1);
      wait_irq(n);
      repeat (256) begin
         if (timer_output_pin === 1'b1) hi++;
         @(negedge sys_clk);
      end
      chk(9'(hi), 9'h07F, "pwm high time");
      chk({8'h00, match_interrupt}, 9'h001, "pwm period");
   endtask

   // a reset in mid-run must hand every pin back as an input and stop the count
   task automatic t_midreset();
      wr(timer_event_pkg::PORT_TWO_DIRECTION_ADDR, 8'h00);
      @(negedge sys_clk);
      reset = 1'b1;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      chk({3'h0, port_pin_oe}, 9'h000, "enables after second reset");
      rd(timer_event_pkg::PORT_TWO_DIRECTION_ADDR, 8'hFF, "direction second reset");
      rd(timer_event_pkg::TIMER_CONTROL_ADDR, 8'h00, "control second reset");
      rd(timer_event_pkg::COUNT_VALUE_ADDR, 8'h00, "count second reset");
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      reset = 1'b1;
      mem_wr = 1'b0;
      mem_rd = 1'b0;
      mem_addr = 16'h0000;
      mem_wdata = 8'h00;
      event_level = 1'b0;
      repeat (16) @(negedge sys_clk);
      reset = 1'b0;
      t_reset();
      t_direction();
      t_interval(8'h00, 8'h03, 9'h004);
      t_interval(8'h00, 8'hFF, 9'h100);
      t_interval(8'h02, 8'h01, 9'h010);
      t_square();
      t_event(8'h04, 1'b0);
      t_event(8'h06, 1'b1);
      t_pwm();
      t_midreset();
      stop_test();
   end
endmodule // timer_event_counter_tb

`default_nettype wire
